// ===== hdl/sct_edge_det.v
// Purpose: edge detector for target-side serial clock and select
// Assumes: inputs already synchronous to the system clock
// Notes: one register stage, pulses last one clock
`timescale 1ns/1ns
`default_nettype none
module sct_edge_det
(
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // Sampled level
  input wire level_in,
  // Edges
  output wire rise_out,
  output wire fall_out,
  output reg level_q_out
);
  // Previous level; reset high suits an idle-high select and a clock that idles high (polarity 1)
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      level_q_out <= 1'b1;
    else
      level_q_out <= level_in;
  end

  assign rise_out = level_in & ~level_q_out;
  assign fall_out = ~level_in & level_q_out;
endmodule
`default_nettype wire

// ===== hdl/sct_port.v
// Purpose: byte-wide full-duplex serial port acting as controller or target
// Assumes: pins sampled synchronously to clk_sys_in at 125 MHz
// Notes: control bits are plain ports; data register accessed by strobes
`timescale 1ns/1ns
`default_nettype none
`include "sct_regs.vh"
module sct_port
(
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // Control bits
  input wire serial_power_gate_bit_in,
  input wire port_enable_in,
  input wire transfer_irq_enable_in,
  input wire lsb_first_in,
  input wire controller_select_set_in,
  input wire controller_select_clr_in,
  input wire clock_polarity_in,
  input wire clock_phase_in,
  input wire rate_select_high_in,
  input wire rate_select_low_in,
  input wire double_rate_bit_in,
  input wire global_irq_enable_in,
  // User pin directions, one means output; select output level
  input wire mosi_dir_out_in,
  input wire sck_dir_out_in,
  input wire ss_dir_out_in,
  input wire miso_dir_out_in,
  input wire ss_gpio_level_in,
  // Data and status access
  input wire data_wr_in,
  input wire [7:0] data_wr_byte_in,
  input wire data_rd_in,
  input wire status_rd_in,
  input wire irq_taken_in,
  output reg [7:0] port_data_reg_out,
  output wire transfer_complete_flag_out,
  output wire write_collision_flag_out,
  output wire controller_select_bit_out,
  output wire busy_out,
  output wire irq_out,
  // Serial pins
  input wire sck_in,
  output wire sck_out,
  output wire sck_oe_out,
  input wire mosi_in,
  output wire mosi_out,
  output wire mosi_oe_out,
  input wire miso_in,
  output wire miso_out,
  output wire miso_oe_out,
  input wire ss_n_in,
  output wire ss_n_out,
  output wire ss_n_oe_out
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  reg state_q;
  reg ctrl_q;
  reg transfer_complete_flag_q;
  reg write_collision_flag_q;
  reg stat_seen_q;
  reg sck_q;
  reg [7:0] shift_q;
  reg [`SCT_CNT_W-1:0] bits_q;
  reg sampled_q;
  reg out_bit_q;
  wire enabled;
  wire edge_en;
  wire ss_fall;
  wire ss_rise;
  wire ss_q;
  wire sck_rise;
  wire sck_fall;
  wire sck_q_unused;
  wire in_bit;
  wire tgt_lead;
  wire tgt_trail;
  wire ctl_lead;
  wire ctl_trail;
  wire last_ctl;
  wire fallback;
  wire byte_done;
  wire clear_flags;
  wire [7:0] shifted;

  assign enabled = port_enable_in & ~serial_power_gate_bit_in;

  sct_rate_div u_div
  (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .run_in(enabled & ctrl_q & (state_q == ST_SHIFT)),
    .rate_sel_in({rate_select_high_in, rate_select_low_in}),
    .double_rate_bit_in(double_rate_bit_in),
    .edge_en_out(edge_en)
  );

  // Target select edges
  sct_edge_det u_ss
  (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .level_in(ss_n_in),
    .rise_out(ss_rise),
    .fall_out(ss_fall),
    .level_q_out(ss_q)
  );

  // external clock edges, sampled at system rate
  sct_edge_det u_sck
  (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .level_in(sck_in),
    .rise_out(sck_rise),
    .fall_out(sck_fall),
    .level_q_out(sck_q_unused)
  );

  // leading edge leaves idle level, trailing edge returns
  assign tgt_lead = clock_polarity_in ? sck_fall : sck_rise;
  assign tgt_trail = clock_polarity_in ? sck_rise : sck_fall;
  assign ctl_lead = edge_en & (sck_q == clock_polarity_in);
  assign ctl_trail = edge_en & (sck_q != clock_polarity_in);

  // controller samples MISO, target samples MOSI
  assign in_bit = ctrl_q ? miso_in : mosi_in;
  assign last_ctl = ctl_trail & (bits_q == `SCT_BITS - 4'h1);

  assign fallback = enabled & ctrl_q & ~ss_dir_out_in & ~ss_n_in;

  // target completes the cycle after its eighth sample while selected
  assign byte_done = enabled & ((ctrl_q & last_ctl) |
    (~ctrl_q & ~ss_n_in & (state_q == ST_SHIFT) & (bits_q == `SCT_BITS) & ~ss_rise));

  // status read seen with a flag set, then data access
  assign clear_flags = irq_taken_in | (stat_seen_q & (data_rd_in | data_wr_in));

  // Next shift contents after taking one bit in
  assign shifted = lsb_first_in ? {sampled_q, shift_q[7:1]} : {shift_q[6:0], sampled_q};

  // Controller select bit and flags
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_q <= `SCT_CTRL_RESET;
      transfer_complete_flag_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      stat_seen_q <= 1'b0;
    end
    else
    begin
      // hardware clear wins over a software set
      if (fallback)
        ctrl_q <= 1'b0;
      else if (controller_select_set_in)
        ctrl_q <= 1'b1;
      else if (controller_select_clr_in)
        ctrl_q <= 1'b0;
      if (byte_done | fallback)
        transfer_complete_flag_q <= 1'b1;
      else if (clear_flags)
        transfer_complete_flag_q <= 1'b0;
      if (data_wr_in & enabled & (state_q == ST_SHIFT))
        write_collision_flag_q <= 1'b1;
      else if (clear_flags)
        write_collision_flag_q <= 1'b0;
      if (status_rd_in & (transfer_complete_flag_q | write_collision_flag_q))
        stat_seen_q <= 1'b1;
      else if (data_rd_in | data_wr_in | irq_taken_in)
        stat_seen_q <= 1'b0;
    end
  end

  // Shift engine for both modes
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= ST_IDLE;
      sck_q <= 1'b0;
      shift_q <= `SCT_DATA_RESET;
      bits_q <= {`SCT_CNT_W{1'b0}};
      sampled_q <= 1'b0;
      out_bit_q <= 1'b0;
      port_data_reg_out <= `SCT_DATA_RESET;
    end
    else if (!enabled || fallback)
    begin
      // Abort any transfer; idle clock level follows polarity
      state_q <= ST_IDLE;
      sck_q <= clock_polarity_in;
      bits_q <= {`SCT_CNT_W{1'b0}};
      if (data_wr_in)
        shift_q <= data_wr_byte_in;
    end
    else if (ctrl_q)
    begin
      if (state_q == ST_IDLE)
      begin
        sck_q <= clock_polarity_in;
        // each new write starts another byte
        if (data_wr_in)
        begin
          shift_q <= data_wr_byte_in;
          state_q <= ST_SHIFT;
          bits_q <= {`SCT_CNT_W{1'b0}};
        end
      end
      else
      begin
        // writes here only raise the collision flag
        if (edge_en)
          sck_q <= ~sck_q;
        // Sample edge holds the bit; the setup edge shifts it in
        if (clock_phase_in ? ctl_trail : ctl_lead)
          sampled_q <= in_bit;
        // Phase 1 skips the first leading edge so the first bit is not lost
        if (clock_phase_in ? (ctl_lead & (bits_q != {`SCT_CNT_W{1'b0}})) : ctl_trail)
          shift_q <= shifted;
        if (ctl_trail)
          bits_q <= bits_q + 4'h1;
        if (last_ctl)
        begin
          state_q <= ST_IDLE;
          sck_q <= clock_polarity_in;
          port_data_reg_out <= clock_phase_in ?
            (lsb_first_in ? {in_bit, shift_q[7:1]} : {shift_q[6:0], in_bit}) : shifted;
        end
      end
    end
    else
    begin
      // select high keeps target idle and drops partial bytes
      if (ss_n_in)
      begin
        state_q <= ST_IDLE;
        bits_q <= {`SCT_CNT_W{1'b0}};
        // load allowed only when no shift is in progress
        if (data_wr_in)
          shift_q <= data_wr_byte_in;
      end
      else
      begin
        state_q <= ST_SHIFT;
        if (data_wr_in & (bits_q == {`SCT_CNT_W{1'b0}}))
          shift_q <= data_wr_byte_in;
        // sample, count and shift on one edge; the other edge redrives the current output bit
        if (clock_phase_in ? tgt_trail : tgt_lead)
        begin
          bits_q <= bits_q + 4'h1;
          shift_q <= lsb_first_in ? {in_bit, shift_q[7:1]} : {shift_q[6:0], in_bit};
          out_bit_q <= lsb_first_in ? shift_q[1] : shift_q[6];
        end
        if (clock_phase_in ? tgt_lead : tgt_trail)
          out_bit_q <= lsb_first_in ? shift_q[0] : shift_q[7];
        if (byte_done)
        begin
          port_data_reg_out <= shift_q;
          bits_q <= {`SCT_CNT_W{1'b0}};
        end
        if (ss_fall)
          out_bit_q <= lsb_first_in ? shift_q[0] : shift_q[7];
      end
    end
  end

  // Status outputs
  assign transfer_complete_flag_out = transfer_complete_flag_q;
  assign write_collision_flag_out = write_collision_flag_q;
  assign controller_select_bit_out = ctrl_q;
  assign busy_out = (state_q == ST_SHIFT);

  // interrupt request gated by enable and global bit
  assign irq_out = transfer_complete_flag_q & transfer_irq_enable_in & global_irq_enable_in;

  assign sck_out = sck_q;
  assign sck_oe_out = enabled & ctrl_q & sck_dir_out_in;
  assign mosi_out = lsb_first_in ? shift_q[0] : shift_q[7];
  assign mosi_oe_out = enabled & ctrl_q & mosi_dir_out_in;
  assign miso_out = out_bit_q;
  assign miso_oe_out = enabled & ~ctrl_q & ~ss_n_in & miso_dir_out_in;
  // select is only a plain output driven by software
  assign ss_n_out = ss_gpio_level_in;
  assign ss_n_oe_out = enabled & ctrl_q & ss_dir_out_in;
endmodule
`default_nettype wire

// ===== hdl/sct_rate_div.v
// Purpose: half-period enable pulse generator for the controller serial clock
// Assumes: one system clock, rate code selects the divisor
// Notes: pulse marks every SCK edge, so the divisor here is half the SCK divisor
`timescale 1ns/1ns
`default_nettype none
`include "sct_regs.vh"
module sct_rate_div
(
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // Control
  input wire run_in,
  input wire [1:0] rate_sel_in,
  input wire double_rate_bit_in,
  // Edge enable
  output reg edge_en_out
);
  reg [`SCT_DIV_W-1:0] cnt_q;
  reg [`SCT_DIV_W-1:0] half_d;

  // Half period of SCK in system clocks
  always @*
  begin
    case ({double_rate_bit_in, rate_sel_in})
      3'h0: half_d = `SCT_RATE0_HALF;
      3'h1: half_d = `SCT_RATE1_HALF;
      3'h2: half_d = `SCT_RATE2_HALF;
      3'h3: half_d = `SCT_RATE3_HALF;
      3'h4: half_d = `SCT_RATE0_HALF_2X;
      3'h5: half_d = `SCT_RATE1_HALF_2X;
      3'h6: half_d = `SCT_RATE2_HALF_2X;
      default: half_d = `SCT_RATE3_HALF_2X;
    endcase
  end

  // Counter restarts whenever idle so the first edge is a full half period away
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q <= {`SCT_DIV_W{1'b0}};
      edge_en_out <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_q <= {`SCT_DIV_W{1'b0}};
      edge_en_out <= 1'b0;
    end
    else if (cnt_q == half_d - 7'h01)
    begin
      cnt_q <= {`SCT_DIV_W{1'b0}};
      edge_en_out <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 7'h01;
      edge_en_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/sct_regs.vh
// Purpose: constants for the controller/target serial port
// Assumes: 8-bit byte shifting, one system clock
// Notes: control bits arrive as plain ports, no register bus
`ifndef SCT_REGS_VH
`define SCT_REGS_VH
`define SCT_BITS 4'h8
`define SCT_CNT_W 4
`define SCT_DIV_W 7
`define SCT_CTRL_RESET 1'b0
`define SCT_DATA_RESET 8'h00
`define SCT_RATE0_HALF 7'h02
`define SCT_RATE1_HALF 7'h08
`define SCT_RATE2_HALF 7'h20
`define SCT_RATE3_HALF 7'h40
`define SCT_RATE0_HALF_2X 7'h01
`define SCT_RATE1_HALF_2X 7'h04
`define SCT_RATE2_HALF_2X 7'h10
`define SCT_RATE3_HALF_2X 7'h20
`endif

// ===== test/sct_peer.sv
// Purpose: behavioural target on the far side of the port
// Assumes: select and clock come from the port as controller
// Notes: released data line shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module sct_peer
(
  // Link and mode
  input wire logic sck_in, ss_n_in, mosi_in, cpol_in, cpha_in, lsb_in,
  input wire logic [7:0] tx_in,
  // Outputs
  output logic miso_out = 1'b1,
  output logic [7:0] rx_out
);
  logic [7:0] sh_q;
  logic first_q;
  // Load on select; with phase 0 the first bit leads the clock
  always @(negedge ss_n_in)
  begin
    sh_q = tx_in;
    first_q = cpha_in;
    rx_out = 8'h00;
    if (!cpha_in) miso_out = lsb_in ? sh_q[0] : sh_q[7];
  end
  // Stale data would hide a sampling slip in the port
  always @(posedge ss_n_in) miso_out = ~miso_out;
  always @(sck_in)
  begin
    if (!ss_n_in)
    begin
      if ((sck_in != cpol_in) != cpha_in)
        rx_out = lsb_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
      else
      begin
        if (!first_q) sh_q = lsb_in ? sh_q >> 1 : sh_q << 1;
        first_q = 1'b0;
        miso_out = lsb_in ? sh_q[0] : sh_q[7];
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/sct_port_props.sv
// Purpose: concurrent checks on the serial port pins and flags
// Assumes: one clock domain, async active-low reset
// Notes: ports grouped per line to keep the checker short
`timescale 1ns/1ns
`default_nettype none
module sct_port_props
(
  // Clock, reset and control
  input wire logic clk_sys_in, reset_n_in, serial_power_gate_bit_in, port_enable_in,
  input wire logic transfer_irq_enable_in, global_irq_enable_in, clock_polarity_in,
  input wire logic ss_dir_out_in, ss_gpio_level_in, data_wr_in, ss_n_in,
  // Status and pins
  input wire logic transfer_complete_flag_out, write_collision_flag_out, controller_select_bit_out,
  input wire logic busy_out, irq_out, sck_out, sck_oe_out, mosi_oe_out, miso_oe_out, ss_n_out, ss_n_oe_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Port usable only when enabled and not gated
  wire logic live = port_enable_in && !serial_power_gate_bit_in;
  wire logic ctl = controller_select_bit_out;

  irq_gating_a: assert property (irq_out == (transfer_complete_flag_out && transfer_irq_enable_in &&
    global_irq_enable_in)) else $error("irq gating wrong");
  write_collision_flag_set_a: assert property (live && ctl && busy_out && data_wr_in |=> write_collision_flag_out)
    else $error("collision flag missing");
  gate_idle_a: assert property (serial_power_gate_bit_in [*2] |-> !busy_out && !sck_oe_out && !miso_oe_out)
    else $error("gated port active");
  tgt_quiet_a: assert property ((!ctl && ss_n_in) [*3] |-> !miso_oe_out && !$rose(transfer_complete_flag_out))
    else $error("deselected target active");
  ctl_miso_a: assert property (ctl [*2] |-> !miso_oe_out) else $error("controller drives miso");
  tgt_inputs_a: assert property (!ctl [*2] |-> !(sck_oe_out || mosi_oe_out || ss_n_oe_out))
    else $error("target drives input pin");
  ss_gpio_a: assert property ((live && ctl && ss_dir_out_in && $stable(ss_gpio_level_in)) [*3] |->
    ss_n_oe_out && ss_n_out == ss_gpio_level_in && ctl) else $error("select gpio wrong");
  fallback_a: assert property (live && ctl && !ss_dir_out_in && !ss_n_in |->
    ##[1:5] !ctl && transfer_complete_flag_out) else $error("no fall-back");
  idle_sck_a: assert property ((live && ctl && !busy_out && $stable(clock_polarity_in)) [*3] |->
    sck_out == clock_polarity_in) else $error("idle clock level wrong");
  done_flag_a: assert property (live && ctl && $fell(busy_out) |-> ##[0:1] transfer_complete_flag_out)
    else $error("flag missing after byte");
endmodule
bind sct_port sct_port_props u_props (.*);
`default_nettype wire

// ===== test/sct_port_test.sv
// Purpose: self-checking bench for the controller/target serial port
// Assumes: 125 MHz clock, far-side target model in sct_peer
// Notes: each of the 8 rate settings runs once and each clock mode twice; bench acts as remote controller
`timescale 1ns/1ns
`default_nettype none
module sct_port_test;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, serial_power_gate_bit_in = 1'b0, port_enable_in = 1'b0;
  logic transfer_irq_enable_in = 1'b0, global_irq_enable_in = 1'b0, lsb_first_in = 1'b0;
  logic controller_select_set_in = 1'b0, controller_select_clr_in = 1'b0, clock_polarity_in = 1'b0;
  logic clock_phase_in = 1'b0, rate_select_high_in = 1'b0, rate_select_low_in = 1'b0, double_rate_bit_in = 1'b0;
  logic mosi_dir_out_in = 1'b1, sck_dir_out_in = 1'b1, ss_dir_out_in = 1'b1, miso_dir_out_in = 1'b1;
  logic ss_gpio_level_in = 1'b1, data_wr_in = 1'b0, data_rd_in = 1'b0, status_rd_in = 1'b0, irq_taken_in = 1'b0;
  logic [7:0] data_wr_byte_in = 8'h00, port_data_reg_out, peer_tx = 8'h00, peer_rx;
  logic transfer_complete_flag_out, write_collision_flag_out, controller_select_bit_out, busy_out, irq_out;
  logic sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, ss_n_out, ss_n_oe_out, peer_miso;
  logic ext_sck = 1'b0, ext_mosi = 1'b0, ext_ss_n = 1'b1;
  wire logic sck_in, mosi_in, miso_in, ss_n_in;
  int err_count = 0, compares = 0, seed = 32'hC6E6B6C6;
  // Half periods indexed by {double rate, rate code}
  int half_tab [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
  // Pin levels from whoever drives each wire
  assign sck_in = sck_oe_out ? sck_out : ext_sck;
  assign mosi_in = mosi_oe_out ? mosi_out : ext_mosi;
  assign miso_in = miso_oe_out ? miso_out : peer_miso;
  assign ss_n_in = ss_n_oe_out ? ss_n_out : ext_ss_n;
  sct_port dut (.*);
  sct_peer peer (.sck_in(sck_in), .ss_n_in(ss_n_in), .mosi_in(mosi_in), .cpol_in(clock_polarity_in),
    .cpha_in(clock_phase_in), .lsb_in(lsb_first_in), .tx_in(peer_tx), .miso_out(peer_miso), .rx_out(peer_rx));
  // Clock
  initial
  begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    data_wr_in <= 1'b1;
    data_wr_byte_in <= b;
    tick(1);
    data_wr_in <= 1'b0;
    tick(1);
  endtask
  task automatic set_ctl();
    controller_select_set_in <= 1'b1;
    tick(1);
    controller_select_set_in <= 1'b0;
    tick(1);
  endtask
  task automatic clr();
    status_rd_in <= 1'b1;
    tick(1);
    status_rd_in <= 1'b0;
    data_rd_in <= 1'b1;
    tick(1);
    data_rd_in <= 1'b0;
    tick(1);
  endtask
  // One controller byte in mode m, with a colliding write a few cycles into the byte
  task automatic ctl_byte(input int m);
    int h, cyc, tog;
    logic [7:0] tx;
    logic last;
    h = half_tab[m];
    tx = $random(seed);
    peer_tx = $random(seed);
    {double_rate_bit_in, rate_select_high_in, rate_select_low_in} <= m[2:0];
    {lsb_first_in, clock_phase_in, clock_polarity_in} <= m[2:0];
    transfer_irq_enable_in <= m[0];
    global_irq_enable_in <= 1'b1;
    tick(2);
    ss_gpio_level_in <= 1'b0;
    tick(4);
    wr(tx);
    cyc = 0;
    tog = 0;
    last = sck_out;
    while (transfer_complete_flag_out !== 1'b1 && cyc < 2000)
    begin
      data_wr_in <= (cyc == 3);
      data_wr_byte_in <= ~tx;
      tick(1);
      cyc++;
      tog += (sck_out !== last);
      last = sck_out;
    end
    data_wr_in <= 1'b0;
    chk("clock edges", tog, 16);
    chk("byte time", (cyc >= 16 * h - 4 && cyc <= 16 * h + 4), 1);
    chk("collision", write_collision_flag_out, 1);
    chk("rx byte", port_data_reg_out, peer_tx);
    chk("peer rx", peer_rx, tx);
    chk("irq", irq_out, m[0]);
    chk("ctl bit", controller_select_bit_out, 1);
    clr();
    chk("flags", {transfer_complete_flag_out, write_collision_flag_out}, 0);
    ss_gpio_level_in <= 1'b1;
    tick(4);
  endtask
  task automatic tgt_bits(input int n, input logic [7:0] mo, output logic [7:0] mi);
    for (int i = 7; i > 7 - n; i--)
    begin
      ext_mosi <= mo[i];
      tick(4);
      mi[i] = miso_in;
      ext_sck <= 1'b1;
      tick(4);
      ext_sck <= 1'b0;
    end
    tick(4);
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] tx, mo, mi;
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    port_enable_in <= 1'b1;
    tick(2);
    set_ctl();
    for (int m = 0; m < 8; m++) ctl_byte(m);
    serial_power_gate_bit_in <= 1'b1;
    wr(8'h5A);
    tick(40);
    chk("gated flag", transfer_complete_flag_out, 0);
    serial_power_gate_bit_in <= 1'b0;
    set_ctl();
    transfer_irq_enable_in <= 1'b1;
    ss_dir_out_in <= 1'b0;
    tick(4);
    ext_ss_n <= 1'b0;
    tick(8);
    chk("fallback ctl", controller_select_bit_out, 0);
    chk("fallback irq", {transfer_complete_flag_out, irq_out}, 8'h03);
    irq_taken_in <= 1'b1;
    tick(1);
    irq_taken_in <= 1'b0;
    ext_ss_n <= 1'b1;
    {clock_polarity_in, clock_phase_in, lsb_first_in} <= 3'h0;
    tick(4);
    chk("taken flag", transfer_complete_flag_out, 0);
    chk("idle miso", miso_oe_out, 0);
    tx = $random(seed);
    mo = $random(seed);
    wr(tx);
    ext_ss_n <= 1'b0;
    tgt_bits(3, ~mo, mi);
    ext_ss_n <= 1'b1;
    tick(6);
    chk("partial flag", transfer_complete_flag_out, 0);
    wr(tx);
    ext_ss_n <= 1'b0;
    tick(4);
    chk("active miso", miso_oe_out, 1);
    tgt_bits(8, mo, mi);
    chk("target flag", transfer_complete_flag_out, 1);
    chk("target rx", port_data_reg_out, mo);
    chk("target tx", mi, tx);
    ext_ss_n <= 1'b1;
    wrap_up();
  end
  // Watchdog well past the longest expected run
  initial
  begin
    repeat (60000) @(posedge clk_sys_in);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
